// *** src/cbt_pkg.sv ***
package cbt_pkg;

  // Register indices (printed offsets are not word aligned, byte address = 4 * index)
  localparam logic [15:0] CBT_IDX_TIMER_CH7 = 16'h1027;
  localparam logic [15:0] CBT_IDX_TIMER_CH8 = 16'h1028;
  // Control register of our own: balancing enables
  localparam logic [15:0] CBT_IDX_CTRL      = 16'h1000;
  localparam int          CBT_ADDR_W        = 18;
  localparam logic [CBT_ADDR_W-1:0] CBT_ADDR_CH7  = {CBT_IDX_TIMER_CH7, 2'b00};
  localparam logic [CBT_ADDR_W-1:0] CBT_ADDR_CH8  = {CBT_IDX_TIMER_CH8, 2'b00};
  localparam logic [CBT_ADDR_W-1:0] CBT_ADDR_CTRL = {CBT_IDX_CTRL, 2'b00};

  // Count field layout
  localparam int          CBT_CNT_W   = 14;
  localparam int          CBT_CNT_LSB = 0;
  localparam int          CBT_CNT_MSB = 13;
  localparam int          CBT_RSV_MSB = 15;
  localparam int          CBT_RSV_LSB = 14;
  localparam logic [13:0] CBT_CNT_RESET = 14'h0000;
  localparam logic [13:0] CBT_CNT_MAX   = 14'h3FFF;
  localparam logic [13:0] CBT_CNT_ONE   = 14'h0001;

  // Control register bit positions
  localparam int CBT_CTRL_GLOBAL = 0;
  localparam int CBT_CTRL_TIMED  = 1;
  localparam int CBT_CTRL_CH7    = 2;
  localparam int CBT_CTRL_CH8    = 3;
  localparam logic [3:0] CBT_CTRL_RESET = 4'h0;

  // Tick timing: one count step is ten seconds
  localparam longint CBT_CLK_HZ      = 100000000;
  localparam longint CBT_TICK_S      = 10;
  localparam longint CBT_TICK_CYCLES = CBT_CLK_HZ * CBT_TICK_S;
  localparam int     CBT_TICK_W      = 30;

  // Avalon-MM request bundle
  typedef struct packed {
    logic                  read;
    logic                  write;
    logic [CBT_ADDR_W-1:0] address;
    logic [31:0]           writedata;
  } cbt_req_t;

endpackage : cbt_pkg

// *** src/cbt_channel.sv ***
`timescale 1ns/1ps
`default_nettype none
module cbt_channel
(
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  // Control
  input  wire logic                          load,
  input  wire logic [cbt_pkg::CBT_CNT_W-1:0] loadValue,
  input  wire logic                          countEn,
  input  wire logic                          tick,
  // State
  output logic      [cbt_pkg::CBT_CNT_W-1:0] count,
  output logic                               balanceOn
);

  import cbt_pkg::*;

  logic [CBT_CNT_W-1:0] next_count;
  wire                  isZero = (count == CBT_CNT_RESET);

  // Write wins over a tick in the same cycle; zero holds
  always_comb
  begin
    next_count = count;
    if (load)
      next_count = loadValue;                                  // see RQ8
    else if (countEn && tick && !isZero)                       // see RQ5 see RQ11
      next_count = count - CBT_CNT_ONE;                        // see RQ3
  end

  // Counter register, timer_run_out_value after reset
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      count <= CBT_CNT_RESET;                                  // see RQ7
    else
      count <= next_count;
  end

  // Balancing gate follows the next count so it is registered yet in step
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      balanceOn <= 1'b0;
    else
      balanceOn <= (next_count != CBT_CNT_RESET);              // see RQ4
  end

  a_zero_stops: assert property (@(posedge core_clk) disable iff (rst)
    (count == CBT_CNT_RESET) |-> !balanceOn)                   // see RQ4
    else $error("balancing active with zero count");
  a_hold_zero: assert property (@(posedge core_clk) disable iff (rst)
    (isZero && !load) |=> isZero)                              // see RQ3
    else $error("count wrapped below zero");
  a_hold_idle: assert property (@(posedge core_clk) disable iff (rst)
    (!load && !countEn) |=> $stable(count))                    // see RQ5
    else $error("count moved while not enabled");
  a_step_one: assert property (@(posedge core_clk) disable iff (rst)
    (!load && countEn && tick && !isZero) |=> (count == $past(count) - CBT_CNT_ONE)) // see RQ11
    else $error("count did not step by one");

endmodule : cbt_channel
`default_nettype wire

// *** src/cbt_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
// How it works
// RQ1 - 14-bit count, upper two bits read zero
// RQ2 - Read returns live counter value
// RQ3 - Counter saturates at zero, never wraps
// RQ4 - Zero count halts that channel's balancing
// RQ5 - Counts only with global, timed, channel enables
// RQ6 - Each count step is ten seconds
// RQ7 - Reset leaves count zero, timer_run_out_value
// RQ8 - All-ones count is largest load
// RQ9 - Channel 7 timer at index 1027h
// RQ10 - Channel 8 timer at index 1028h
// RQ11 - Ten-second tick decrements active counter
module cbt_timer
#(
  parameter longint TICK_CYCLES = cbt_pkg::CBT_TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           rst,
  // Avalon-MM slave
  input  wire logic [cbt_pkg::CBT_ADDR_W-1:0] avs_address,
  input  wire logic                           avs_read,
  input  wire logic                           avs_write,
  input  wire logic [31:0]                    avs_writedata,
  input  wire logic [3:0]                     avs_byteenable,
  output logic      [31:0]                    avs_readdata,
  output logic                                avs_waitrequest,
  output logic      [1:0]                     avs_response,
  // Balancing gates
  output logic                                balanceCh7,
  output logic                                balanceCh8
);

  import cbt_pkg::*;

  cbt_req_t req;
  assign req = '{read: avs_read, write: avs_write, address: avs_address, writedata: avs_writedata};

  localparam logic [CBT_TICK_W-1:0] TICK_LAST = CBT_TICK_W'(TICK_CYCLES - 1);

  logic [CBT_TICK_W-1:0] tickCnt;
  logic                  tick;
  logic [3:0]            ctrl;
  logic                  busy;
  logic [CBT_CNT_W-1:0] count7;
  logic [CBT_CNT_W-1:0] count8;
  logic                  bal7;
  logic                  bal8;

  // Divider for the ten-second tick; free running so channels share one time base
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tickCnt <= '0;
      tick    <= 1'b0;
    end
    else
    begin
      tick    <= (tickCnt == TICK_LAST);                        // see RQ6
      tickCnt <= (tickCnt == TICK_LAST) ? '0 : tickCnt + 1'b1;  // see RQ11
    end
  end

  // Address decode
  wire selCh7  = (req.address == CBT_ADDR_CH7);                 // see RQ9
  wire selCh8  = (req.address == CBT_ADDR_CH8);                 // see RQ10
  wire selCtrl = (req.address == CBT_ADDR_CTRL);
  wire mapped  = selCh7 | selCh8 | selCtrl;
  // Accept in the second cycle of a request: one wait state
  wire accept  = (req.read | req.write) & busy;
  wire wrLow   = req.write & accept & avs_byteenable[0];
  wire wrHigh  = req.write & accept & avs_byteenable[1];
  wire wrCount = wrLow & wrHigh;

  // Load value, partial byte writes merge with live count
  wire [CBT_CNT_W-1:0] load7 = {avs_byteenable[1] ? req.writedata[CBT_CNT_MSB:8] : count7[CBT_CNT_MSB:8],
                                avs_byteenable[0] ? req.writedata[7:0] : count7[7:0]};
  wire [CBT_CNT_W-1:0] load8 = {avs_byteenable[1] ? req.writedata[CBT_CNT_MSB:8] : count8[CBT_CNT_MSB:8],
                                avs_byteenable[0] ? req.writedata[7:0] : count8[7:0]};
  wire ld7 = (wrLow | wrHigh) & selCh7;
  wire ld8 = (wrLow | wrHigh) & selCh8;

  // Enables for each channel
  wire run7 = ctrl[CBT_CTRL_GLOBAL] & ctrl[CBT_CTRL_TIMED] & ctrl[CBT_CTRL_CH7];  // see RQ5
  wire run8 = ctrl[CBT_CTRL_GLOBAL] & ctrl[CBT_CTRL_TIMED] & ctrl[CBT_CTRL_CH8];  // see RQ5

  // Read mux: reserved bits and unused lanes zero
  wire [31:0] rdMux = selCh7  ? {18'h00000, count7} :           // see RQ1 see RQ2
                      selCh8  ? {18'h00000, count8} :
                      selCtrl ? {28'h0000000, ctrl} : 32'h00000000;

  // Wait state toggle
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      busy <= 1'b0;
    else
      busy <= (req.read | req.write) & !busy;
  end

  // Control register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ctrl <= CBT_CTRL_RESET;
    else if (wrLow & selCtrl)
      ctrl <= req.writedata[3:0];
  end

  // Bus answer registers; unmapped gives slave error
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      avs_readdata    <= 32'h00000000;
      avs_waitrequest <= 1'b1;
      avs_response    <= 2'h0;
    end
    else
    begin
      avs_waitrequest <= !((req.read | req.write) & !busy);
      avs_readdata    <= rdMux;
      avs_response    <= mapped ? 2'h0 : 2'h2;
    end
  end

  // Two channel timers
  cbt_channel u_ch7 (
    .core_clk  (core_clk),
    .rst       (rst),
    .load      (ld7),
    .loadValue (load7),
    .countEn   (run7),
    .tick      (tick),
    .count     (count7),
    .balanceOn (bal7)
  );

  cbt_channel u_ch8 (
    .core_clk  (core_clk),
    .rst       (rst),
    .load      (ld8),
    .loadValue (load8),
    .countEn   (run8),
    .tick      (tick),
    .count     (count8),
    .balanceOn (bal8)
  );

  assign balanceCh7 = bal7;
  assign balanceCh8 = bal8;

  a_read_live: assert property (@(posedge core_clk) disable iff (rst)
    (avs_read & busy & selCh7) |=> (avs_readdata == {18'h00000, $past(count7)}))   // see RQ2
    else $error("channel 7 read is not the live count");
  a_rsv_zero: assert property (@(posedge core_clk) disable iff (rst)
    (avs_readdata[31:CBT_RSV_LSB] == 18'h00000))                  // see RQ1
    else $error("reserved bits read nonzero");
  a_ch8_write: assert property (@(posedge core_clk) disable iff (rst)
    (wrCount & selCh8) |=> (count8 == $past(req.writedata[CBT_CNT_MSB:0])))        // see RQ10
    else $error("channel 8 write not taken");
  a_ch7_only: assert property (@(posedge core_clk) disable iff (rst)
    (ld7 & !run8) |=> $stable(count8))                            // see RQ9
    else $error("channel 7 write disturbed channel 8");
  a_tick_gap: assert property (@(posedge core_clk) disable iff (rst)
    tick |=> !tick)                                               // see RQ6
    else $error("tick longer than one cycle");

  // Checker helpers below; nothing here feeds the datapath
  // Cycles since the last tick, so the period is checked by a counter, not a long repetition
  logic [CBT_TICK_W-1:0] tickGap;
  logic                  tickSeen;

  // The first gap after reset is one longer, so the check waits for a first tick
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tickGap  <= '0;
      tickSeen <= 1'b0;
    end
    else if (tick)
    begin
      tickGap  <= '0;
      tickSeen <= 1'b1;
    end
    else
      tickGap <= tickGap + 1'b1;
  end

  // Steps of one bus access: request from idle, one wait state, then back to idle
  sequence s_bus_start;
    (avs_read | avs_write) && !busy;
  endsequence

  sequence s_bus_answer;
    !avs_waitrequest && busy;
  endsequence

  sequence s_bus_done;
    avs_waitrequest && !busy;
  endsequence

  // One decrement step of a running, nonzero counter
  sequence s_step7;
    run7 && tick && !ld7 && (count7 != CBT_CNT_RESET);
  endsequence

  sequence s_step8;
    run8 && tick && !ld8 && (count8 != CBT_CNT_RESET);
  endsequence

  // Exactly one wait state per access, then back to idle
  a_bus_handshake: assert property (@(posedge core_clk) disable iff (rst)
    s_bus_start |=> s_bus_answer ##1 s_bus_done)
    else $error("bus access did not take exactly one wait state");

  // No request, no answer
  a_wait_idle: assert property (@(posedge core_clk) disable iff (rst)
    (!(avs_read | avs_write) && !busy) |=> avs_waitrequest)
    else $error("waitrequest low without a request");

  // The answer stands for one cycle only
  a_answer_once: assert property (@(posedge core_clk) disable iff (rst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  // Unmapped addresses answer with a slave error
  a_resp_error: assert property (@(posedge core_clk) disable iff (rst)
    s_bus_start ##0 !mapped |=> (avs_response == 2'h2))
    else $error("unmapped access not answered with an error");

  a_resp_okay: assert property (@(posedge core_clk) disable iff (rst)
    s_bus_start ##0 mapped |=> (avs_response == 2'h0))
    else $error("mapped access answered with an error");

  // Read data at the answering edge is the count of the cycle before
  a_read_ch7: assert property (@(posedge core_clk) disable iff (rst) // see RQ2 see RQ9
    (avs_read && !avs_waitrequest && selCh7) |-> (avs_readdata == {18'h00000, $past(count7)}))
    else $error("channel 7 answer is not the live count");

  a_read_ch8: assert property (@(posedge core_clk) disable iff (rst) // see RQ2 see RQ10
    (avs_read && !avs_waitrequest && selCh8) |-> (avs_readdata == {18'h00000, $past(count8)}))
    else $error("channel 8 answer is not the live count");

  // Control bits read back in the low nibble
  a_read_ctrl: assert property (@(posedge core_clk) disable iff (rst)
    (avs_read && !avs_waitrequest && selCtrl) |-> (avs_readdata == {28'h0000000, $past(ctrl)}))
    else $error("control read back wrong");

  // Unmapped reads return zero
  a_read_unmapped: assert property (@(posedge core_clk) disable iff (rst)
    (avs_read && !avs_waitrequest && !mapped) |-> (avs_readdata == 32'h00000000))
    else $error("unmapped read returned data");

  // Control register takes only its own writes
  a_ctrl_write: assert property (@(posedge core_clk) disable iff (rst)
    (wrLow && selCtrl) |=> (ctrl == $past(req.writedata[3:0])))
    else $error("control write not taken");

  a_ctrl_hold: assert property (@(posedge core_clk) disable iff (rst)
    !(wrLow && selCtrl) |=> $stable(ctrl))
    else $error("control changed without a write");

  // A full write lands whole in channel 7
  a_ch7_write: assert property (@(posedge core_clk) disable iff (rst) // see RQ8 see RQ9
    (wrCount && selCh7) |=> (count7 == $past(req.writedata[CBT_CNT_MSB:0])))
    else $error("channel 7 write not taken");

  // A channel 8 write leaves channel 7 alone
  a_ch8_only: assert property (@(posedge core_clk) disable iff (rst) // see RQ10
    (ld8 && !run7) |=> $stable(count7))
    else $error("channel 8 write disturbed channel 7");

  // A low-lane write keeps the upper count bits
  a_lane_merge: assert property (@(posedge core_clk) disable iff (rst)
    (wrLow && !wrHigh && selCh8) |=> (count8[CBT_CNT_MSB:8] == $past(count8[CBT_CNT_MSB:8])))
    else $error("low lane write changed upper bits");

  // Gates are high exactly while the count is nonzero
  a_gate_ch7: assert property (@(posedge core_clk) disable iff (rst) // see RQ4
    (balanceCh7 == (count7 != CBT_CNT_RESET)))
    else $error("channel 7 gate out of step with count");

  a_gate_ch8: assert property (@(posedge core_clk) disable iff (rst) // see RQ4
    (balanceCh8 == (count8 != CBT_CNT_RESET)))
    else $error("channel 8 gate out of step with count");

  // A counter that is not enabled holds
  a_idle_ch7: assert property (@(posedge core_clk) disable iff (rst) // see RQ5
    (!run7 && !ld7) |=> $stable(count7))
    else $error("channel 7 moved while not enabled");

  a_idle_ch8: assert property (@(posedge core_clk) disable iff (rst) // see RQ5
    (!run8 && !ld8) |=> $stable(count8))
    else $error("channel 8 moved while not enabled");

  // Ticks come exactly one period apart
  a_tick_period: assert property (@(posedge core_clk) disable iff (rst) // see RQ6
    tickSeen |-> (tick == (tickGap == TICK_LAST)))
    else $error("tick period wrong");

  // Each tick takes one step off a running, nonzero count
  a_step_ch7: assert property (@(posedge core_clk) disable iff (rst) // see RQ11
    s_step7 |=> (count7 == $past(count7) - CBT_CNT_ONE))
    else $error("channel 7 did not step by one");

  a_step_ch8: assert property (@(posedge core_clk) disable iff (rst) // see RQ11
    s_step8 |=> (count8 == $past(count8) - CBT_CNT_ONE))
    else $error("channel 8 did not step by one");

  // A running count at zero stays at zero
  a_floor_ch7: assert property (@(posedge core_clk) disable iff (rst) // see RQ3
    (run7 && tick && !ld7 && (count7 == CBT_CNT_RESET)) |=> (count7 == CBT_CNT_RESET))
    else $error("channel 7 wrapped below zero");

endmodule : cbt_timer
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cbt_pkg::*;
  localparam longint TICKS = 20;
  logic                  core_clk = 1'b0;
  logic                  rst      = 1'b1;
  logic [CBT_ADDR_W-1:0] avsAddress = '0;
  logic                  avsRead = 1'b0;
  logic                  avsWrite = 1'b0;
  logic [31:0]           avsWritedata = 32'h0;
  logic [3:0]            avsByteEn = 4'hF;
  logic [31:0]           rdData;
  logic [1:0]            rdResp;
  wire logic [31:0]      avs_readdata;
  wire logic             avs_waitrequest;
  wire logic [1:0]       avs_response;
  wire logic             balanceCh7;
  wire logic             balanceCh8;
  int                    num_errors = 0;
  int                    tests_run = 0;
  int                    cycles = 0;
  cbt_timer #(.TICK_CYCLES(TICKS)) dut (.core_clk(core_clk), .rst(rst), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_byteenable(avsByteEn),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .balanceCh7(balanceCh7), .balanceCh8(balanceCh8));
  // Clock, and a ceiling well above the expected run length
  initial
  begin
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      num_errors++;
      conclude();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // One bus access; held until waitrequest is sampled low
  task automatic busOp(input logic wr, input logic [CBT_ADDR_W-1:0] addr, input logic [31:0] wdata);
    @(posedge core_clk);
    avsWrite <= wr;
    avsRead <= !wr;
    avsAddress <= addr;
    avsWritedata <= wdata;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rdData = avs_readdata;
    rdResp = avs_response;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask : busOp
  task automatic readCheck(input string what, input logic [CBT_ADDR_W-1:0] addr, input logic [31:0] exp);
    busOp(1'b0, addr, 32'h0);
    check(what, exp, rdData);
  endtask : readCheck
  task automatic resetState;
    readCheck("ch7 reset", CBT_ADDR_CH7, 32'h0);
    check("ch7 resp", 32'h0, {30'h0, rdResp});
    readCheck("ch8 reset", CBT_ADDR_CH8, 32'h0);
    check("gates reset", 32'h0, {30'h0, balanceCh7, balanceCh8});
  endtask : resetState
  // Upper bits of a write must be dropped, and only the addressed channel changes
  task automatic fieldAndMap;
    busOp(1'b1, CBT_ADDR_CH7, 32'hFFFF_FFFF);
    readCheck("ch7 max", CBT_ADDR_CH7, 32'h3FFF);
    readCheck("ch8 untouched", CBT_ADDR_CH8, 32'h0);
    check("gate ch7 on", 32'h2, {30'h0, balanceCh7, balanceCh8});
    busOp(1'b1, CBT_ADDR_CH8, 32'h0000_C123);
    readCheck("ch8 load", CBT_ADDR_CH8, 32'h0123);
    // Low lane only: upper count bits must be kept
    avsByteEn <= 4'h1;
    busOp(1'b1, CBT_ADDR_CH8, 32'h0000_FFFF);
    avsByteEn <= 4'hF;
    readCheck("ch8 low lane", CBT_ADDR_CH8, 32'h01FF);
    busOp(1'b1, CBT_ADDR_CH7, 32'h0);
    // Gates update on the accepting edge, so look one edge later
    @(posedge core_clk);
    check("gate ch7 off", 32'h1, {30'h0, balanceCh7, balanceCh8});
    busOp(1'b0, 18'h0, 32'h0);
    check("unmapped resp", 32'h2, {30'h0, rdResp});
    check("unmapped data", 32'h0, rdData);
  endtask : fieldAndMap
  // Each missing enable must freeze the count
  task automatic holdWhenDisabled;
    logic [3:0] ctl [3] = '{4'hE, 4'hD, 4'hB};
    foreach (ctl[i])
    begin
      busOp(1'b1, CBT_ADDR_CH7, 32'h5);
      busOp(1'b1, CBT_ADDR_CTRL, {28'h0, ctl[i]});
      readCheck("ctrl readback", CBT_ADDR_CTRL, {28'h0, ctl[i]});
      repeat (3 * TICKS) @(posedge core_clk);
      readCheck("ch7 held", CBT_ADDR_CH7, 32'h5);
    end
  endtask : holdWhenDisabled
  // Live countdown; ch7 must stop at zero while ch8 keeps going
  task automatic countdown;
    busOp(1'b1, CBT_ADDR_CTRL, 32'h0);
    busOp(1'b1, CBT_ADDR_CH7, 32'h3);
    busOp(1'b1, CBT_ADDR_CH8, 32'h8);
    busOp(1'b1, CBT_ADDR_CTRL, 32'hF);
    repeat (4 * TICKS + 5) @(posedge core_clk);
    readCheck("ch7 saturated", CBT_ADDR_CH7, 32'h0);
    check("gate ch7 timer_run_out_value", 32'h0, {31'h0, balanceCh7});
    busOp(1'b0, CBT_ADDR_CH8, 32'h0);
    // Free-running divider: four or five steps in that span
    check("ch8 steps", 32'h1, {31'h0, rdData === 32'h3 || rdData === 32'h4});
    check("gate ch8 on", 32'h1, {31'h0, balanceCh8});
  endtask : countdown
  // Reset in mid-run must bring a loaded count back to timer_run_out_value
  task automatic midReset;
    busOp(1'b1, CBT_ADDR_CH8, 32'h0000_0077);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    check("gate ch8 in reset", 32'h0, {31'h0, balanceCh8});
    readCheck("ch8 after reset", CBT_ADDR_CH8, 32'h0);
    readCheck("ctrl after reset", CBT_ADDR_CTRL, 32'h0);
  endtask : midReset
  task automatic conclude;
    $display("Checks run %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    resetState();
    fieldAndMap();
    holdWhenDisabled();
    countdown();
    midReset();
    conclude();
  end
endmodule : testbench
`default_nettype wire
